// [design/aoc_fifo.sv]
`timescale 1ns/10ps
module aoc_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  // Storage has no reset; contents are qualified by the count
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else if (flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [design/aoc_top.sv]
`timescale 1ns/10ps
// Function
// [R01] Offset binary: midscale 0x2000 at zero, all ones +full, all zeros -full.
// [R02] Two's complement is offset binary with top bit inverted.
// [R03] Over-range raises flag and saturates word at the matching extreme code.
// [R04] Config pin: GND OB/off, 1/3 OB/on, 2/3 2C/on, VDD 2C/off.
// [R05] Output enable high puts word and flag into high impedance.
// [R06] Power-down with enable high is sleep; recovery takes milliseconds.
// [R07] Power-down with enable low is nap; recovery takes 100 cycles.
// [R08] Sleep and nap hold all digital outputs in high impedance.
// [R09] Clock source stays between 1 and 10 Msps.
// [R10] Stabilizer off: clock duty 50 percent within ten, phases at least 40ns.
// [R11] Stabilizer on: sample on rising edge, internal 50 percent duty.
// [R12] Stabilizer needs about 100 cycles to relock after a stopped clock.
// [R13] Result appears five clock cycles after its sample. Here only with the FIFO empty; queued words come later.
// [R14] Track while clock low, hold at rising edge.
// [R15] Capture logic registers each cycle and drops invalid samples.
module aoc_top
  import aoc_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [aoc_pkg::SAMPLE_W-1:0] quantCode,
  input  wire logic                      quantOverHi,
  input  wire logic                      quantOverLo,
  input  wire logic [1:0]                cfgLevel,
  input  wire logic                      outEnable_n,
  input  wire logic                      power_down_pin,
  input  wire logic                      clkGapSeen,
  output logic [aoc_pkg::SAMPLE_W-1:0]   sample_word,
  output logic                           over_range_flag,
  output logic                           dataOe_n,
  output logic                           sampleValid,
  output logic                           stabOn,
  output logic                           twosComp,
  output logic                           refPowered,
  output logic                           corePowered,
  output logic                           fifoFull
);
  import aoc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cfgMeta_q;
  logic [1:0] cfgSync_q;
  logic       oeMeta_q;
  logic       oeSync_q;
  logic       pdMeta_q;
  logic       pdSync_q;
  logic       gapMeta_q;
  logic       gapSync_q;

  // Static pins are asynchronous to the sample clock
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfgMeta_q <= 2'h0;
      cfgSync_q <= 2'h0;
      oeMeta_q  <= 1'b1;
      oeSync_q  <= 1'b1;
      pdMeta_q  <= 1'b0;
      pdSync_q  <= 1'b0;
      gapMeta_q <= 1'b0;
      gapSync_q <= 1'b0;
    end
    else
    begin
      cfgMeta_q <= cfgLevel;
      cfgSync_q <= cfgMeta_q;
      oeMeta_q  <= outEnable_n;
      oeSync_q  <= oeMeta_q;
      pdMeta_q  <= power_down_pin;
      pdSync_q  <= pdMeta_q;
      gapMeta_q <= clkGapSeen;
      gapSync_q <= gapMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  // Middle levels enable the stabilizer; upper half selects 2's complement
  always_comb
  begin
    unique case (cfgSync_q)
      CFG_GND:
      begin
        twosComp = 1'b0; // R04
        stabOn   = 1'b0;
      end
      CFG_THIRD:
      begin
        twosComp = 1'b0; // R04
        stabOn   = 1'b1;
      end
      CFG_TWOTHIRD:
      begin
        twosComp = 1'b1; // R04
        stabOn   = 1'b1;
      end
      CFG_VDD:
      begin
        twosComp = 1'b1; // R04
        stabOn   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Stabilizer lock tracking
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] lockCnt_q;
  logic             locked;
  logic             stabOnDly_q;

  // Lock is lost on a stopped clock or when the stabilizer is turned on
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lockCnt_q   <= '0;
      stabOnDly_q <= 1'b0;
    end
    else
    begin
      stabOnDly_q <= stabOn;
      if (!stabOn)
        lockCnt_q <= '0;
      else if (gapSync_q || !stabOnDly_q)
        lockCnt_q <= '0; // R12
      else if (lockCnt_q != CNT_W'(RELOCK_CYC))
        lockCnt_q <= lockCnt_q + 1'b1; // R12
    end
  end

  assign locked = !stabOn || (lockCnt_q == CNT_W'(RELOCK_CYC)); // R11

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  aoc_pwr_t         pwrState_q;
  logic [31:0]      wakeCnt_q;
  logic [31:0]      wakeTarget_q;

  // Mode is chosen by power-down together with output enable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwrState_q   <= PWR_RUN;
      wakeCnt_q    <= '0;
      wakeTarget_q <= '0;
    end
    else
    begin
      unique case (pwrState_q)
        PWR_RUN:
        begin
          if (pdSync_q && oeSync_q)
            pwrState_q <= PWR_SLEEP; // R06
          else if (pdSync_q)
            pwrState_q <= PWR_NAP; // R07
        end
        PWR_NAP:
        begin
          if (pdSync_q && oeSync_q)
            pwrState_q <= PWR_SLEEP; // R06
          else if (!pdSync_q)
          begin
            pwrState_q   <= PWR_WAKE;
            wakeCnt_q    <= '0;
            wakeTarget_q <= 32'(NAP_RECOVER_CYC); // R07
          end
        end
        PWR_SLEEP:
        begin
          if (pdSync_q && !oeSync_q)
            pwrState_q <= PWR_NAP; // R07
          else if (!pdSync_q)
          begin
            pwrState_q   <= PWR_WAKE;
            wakeCnt_q    <= '0;
            wakeTarget_q <= 32'(SLEEP_RECOVER_CYC); // R06
          end
        end
        PWR_WAKE:
        begin
          if (pdSync_q)
            pwrState_q <= oeSync_q ? PWR_SLEEP : PWR_NAP;
          else if (wakeCnt_q + 32'h1 >= wakeTarget_q)
            pwrState_q <= PWR_RUN;
          else
            wakeCnt_q <= wakeCnt_q + 32'h1;
        end
      endcase
    end
  end

  // Reference stays up in nap only, core down in both low-power modes
  assign refPowered  = (pwrState_q != PWR_SLEEP); // R06
  assign corePowered = (pwrState_q == PWR_RUN) || (pwrState_q == PWR_WAKE); // R07

  // ----------------------------------------------------------------
  // Sample hold and coding
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] heldCode;
  logic                heldOver;

  // Saturate over-range to the matching extreme offset-binary code
  always_comb
  begin
    if (quantOverHi)
      heldCode = CODE_MAX; // R03
    else if (quantOverLo)
      heldCode = CODE_MIN; // R03
    else
      heldCode = quantCode; // R01
    heldOver = quantOverHi || quantOverLo; // R03
    if (twosComp)
      heldCode[SIGN_BIT] = ~heldCode[SIGN_BIT]; // R02
  end

  // ----------------------------------------------------------------
  // Pipeline ahead of the FIFO
  // ----------------------------------------------------------------
  // Stage 0 is the hold at the rising edge; FIFO write and output
  // register follow the last stage, so with the FIFO empty the word
  // reaches the pins five edges after its hold
  localparam int STAGES = PIPE_LATENCY - 1;

  logic [SAMPLE_W:0] pipe_q [STAGES];
  logic [STAGES-1:0] pipeOk_q;
  logic              stageOk;

  assign stageOk = corePowered && locked && (pwrState_q == PWR_RUN);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < STAGES; i++)
        pipe_q[i] <= '0;
      pipeOk_q <= '0;
    end
    else
    begin
      pipe_q[0]   <= {heldOver, heldCode}; // R14
      pipeOk_q[0] <= stageOk;
      for (int i = 1; i < STAGES; i++)
      begin
        pipe_q[i]   <= pipe_q[i-1]; // R13
        pipeOk_q[i] <= pipeOk_q[i-1] && stageOk;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO
  // ----------------------------------------------------------------
  // Drained once per cycle while outputs drive and the stabilizer is locked; stalls while tri-stated,
  // so a parked bus fills the FIFO and fifoFull stalls nothing upstream
  // except by dropping: the converter cannot stop the analog input.
  logic [SAMPLE_W:0] fifoOut;
  logic              fifoValid;
  logic              fifoInReady;
  logic              drive;
  logic              drain;

  assign drive    = !oeSync_q && (pwrState_q == PWR_RUN); // R05 R08
  assign drain    = drive && locked;
  assign fifoFull = !fifoInReady;

  aoc_fifo #(
    .WIDTH (SAMPLE_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inData   (pipe_q[STAGES-1]), // R13
    .inValid  (pipeOk_q[STAGES-1]),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (drain),
    .flush    (!corePowered)
  );

  // ----------------------------------------------------------------
  // Output register and enable
  // ----------------------------------------------------------------
  // Registered output bus; enable low means pins are driven
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sample_word     <= CODE_MIN;
      over_range_flag <= 1'b0;
      sampleValid     <= 1'b0;
      dataOe_n        <= 1'b1;
    end
    else
    begin
      dataOe_n    <= !drive; // R05 R08
      sampleValid <= drain && fifoValid;
      if (drain && fifoValid)
      begin
        sample_word     <= fifoOut[SAMPLE_W-1:0];
        over_range_flag <= fifoOut[SAMPLE_W];
      end
    end
  end
endmodule

// [include/aoc_pkg.sv]
package aoc_pkg;
  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int          SAMPLE_W      = 14;
  localparam logic [13:0] CODE_MIDSCALE = 14'h2000;
  localparam logic [13:0] CODE_MAX      = 14'h3FFF;
  localparam logic [13:0] CODE_MIN      = 14'h0000;
  localparam int          SIGN_BIT      = 13;

  // Four-level configuration pin, quantised by an on-chip comparator ladder
  localparam logic [1:0] CFG_GND      = 2'h0;
  localparam logic [1:0] CFG_THIRD    = 2'h1;
  localparam logic [1:0] CFG_TWOTHIRD = 2'h2;
  localparam logic [1:0] CFG_VDD      = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int PIPE_LATENCY    = 5;
  localparam int NAP_RECOVER_CYC = 100;
  localparam int RELOCK_CYC      = 100;
  // Sleep recovery is milliseconds; figure in microseconds
  localparam int SLEEP_RECOVER_US  = 2000;
  localparam int SLEEP_RECOVER_CYC = SLEEP_RECOVER_US * 1000 / CLK_PERIOD_NS;
  // A clock gap longer than this counts as a stopped clock
  localparam int STOP_GAP_NS  = 1000;
  localparam int STOP_GAP_CYC = STOP_GAP_NS / CLK_PERIOD_NS;

  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W      = 16;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PWR_RUN   = 4'b0001,
    PWR_NAP   = 4'b0010,
    PWR_SLEEP = 4'b0100,
    PWR_WAKE  = 4'b1000
  } aoc_pwr_t;
endpackage

// [sim/adc_output_and_power_control_test.sv]
`timescale 1ns/10ps
module adc_output_and_power_control_test;
  import aoc_pkg::*;
  // Design latency plus the capture register
  localparam int LAT = PIPE_LATENCY + 1;
  logic        clk, sys_rst, quantOverHi, quantOverLo, outEnable_n, power_down_pin;
  logic        clkGapSeen, track, sampleValid, capStrobe, fifoFull, dataOe_n;
  logic        over_range_flag, stabOn, twosComp, refPowered, corePowered;
  logic [13:0] quantCode, sample_word;
  logic [14:0] capData;
  logic [14:0] hist [0:255];
  logic [1:0]  cfgLevel;
  int          fails, samples_checked, cyc, n;

  // ------------------------------------------------------------
  // Clock, design and capture side
  // ------------------------------------------------------------
  // 10 MHz, even duty, so the stabilizer is never needed
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  aoc_top dut_u (.clk(clk), .sys_rst(sys_rst), .quantCode(quantCode),
    .quantOverHi(quantOverHi), .quantOverLo(quantOverLo), .cfgLevel(cfgLevel),
    .outEnable_n(outEnable_n), .power_down_pin(power_down_pin), .clkGapSeen(clkGapSeen),
    .sample_word(sample_word), .over_range_flag(over_range_flag), .dataOe_n(dataOe_n),
    .sampleValid(sampleValid), .stabOn(stabOn), .twosComp(twosComp),
    .refPowered(refPowered), .corePowered(corePowered), .fifoFull(fifoFull));

  aoc_capture_model cap_u (.clk(clk), .busWord(sample_word), .busFlag(over_range_flag),
    .busOe_n(dataOe_n), .busValid(sampleValid), .capData(capData), .capStrobe(capStrobe));

  // Expected word for a sample, saturating first and then recoding
  function automatic logic [14:0] expect_out(input logic [13:0] c, input logic hi, lo, tc);
    logic [13:0] w;
    w = hi ? CODE_MAX : (lo ? CODE_MIN : c);
    w[SIGN_BIT] = w[SIGN_BIT] ^ tc;
    return {hi | lo, w};
  endfunction

  task automatic check(input logic [14:0] got, input logic [14:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // History of what every edge sampled; fixed depth keeps latency exact
  always @(posedge clk)
  begin
    hist[8'(cyc)] <= expect_out(quantCode, quantOverHi, quantOverLo, cfgLevel[1]);
    cyc <= cyc + 1;
  end

  // Captures compared half a cycle later, once the model has settled
  always @(negedge clk)
    if (track && capStrobe) check(capData, hist[8'(cyc - 1 - LAT)]);

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {quantOverHi, quantOverLo, outEnable_n, power_down_pin, clkGapSeen, track} = '0;
    {quantCode, cfgLevel, cyc, fails, samples_checked} = '0;
    // Reset rises off the clock edge so the async branch fires before any edge
    sys_rst = 1'b0;
    #10 sys_rst = 1'b1;
    n = $urandom(82);
    tick(12);
    sys_rst <= 1'b0;
    // Every coding mode with random words and the extreme codes mixed in
    for (int m = 0; m < 4; m++)
    begin
      track <= 1'b0;
      cfgLevel <= m[1:0];
      tick(RELOCK_CYC + 20);
      check({13'h0, stabOn, twosComp}, {13'h0, m == 1 || m == 2, m[1]});
      track <= 1'b1;
      repeat (60)
      begin
        @(posedge clk);
        n = $urandom % 8;
        quantOverHi <= (n == 0);
        quantOverLo <= (n == 1);
        quantCode <= (n == 2) ? CODE_MAX : (n == 3) ? CODE_MIN :
                     (n == 4) ? CODE_MIDSCALE : 14'($urandom);
      end
      @(posedge clk);
      // Flagged samples drain before the coding changes under them
      {quantOverHi, quantOverLo} <= 2'b00;
      tick(LAT + 1);
    end
    // A stopped clock forces relock; no words while unlocked
    track <= 1'b0;
    cfgLevel <= CFG_TWOTHIRD;
    tick(RELOCK_CYC + 20);
    clkGapSeen <= 1'b1;
    tick(1);
    clkGapSeen <= 1'b0;
    tick(20);
    n = 0;
    repeat (70) begin @(posedge clk); n += sampleValid; end
    check(15'(n), 15'h0);
    // Released bus, once relocked, fills the buffer until it refuses
    outEnable_n <= 1'b1;
    tick(RELOCK_CYC + FIFO_DEPTH + 12);
    check({13'h0, dataOe_n, fifoFull}, 15'h3);
    // Nap keeps the reference, then words return no sooner than the recovery time
    outEnable_n <= 1'b0;
    power_down_pin <= 1'b1;
    tick(10);
    check({12'h0, dataOe_n, refPowered, corePowered}, 15'h6);
    power_down_pin <= 1'b0;
    for (n = 0; n < NAP_RECOVER_CYC + LAT + 20 && sampleValid !== 1'b1; n++) tick(1);
    check({14'h0, sampleValid}, 15'h1);
    check({14'h0, n >= NAP_RECOVER_CYC}, 15'h1);
    if (sampleValid !== 1'b1)
      conclude();
    // Sleep drops both domains and stays quiet long after wake
    outEnable_n <= 1'b1;
    power_down_pin <= 1'b1;
    tick(10);
    check({12'h0, dataOe_n, refPowered, corePowered}, 15'h4);
    power_down_pin <= 1'b0;
    outEnable_n <= 1'b0;
    n = 0;
    repeat (200) begin @(posedge clk); n += sampleValid; end
    check(15'(n), 15'h0);
    conclude();
  end
endmodule

// [sim/aoc_assertions.sv]
`timescale 1ns/10ps
module aoc_checker
  import aoc_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          sys_rst,
  input wire logic [1:0]                    cfgLevel,
  input wire logic                          outEnable_n,
  input wire logic                          power_down_pin,
  input wire logic [aoc_pkg::SAMPLE_W-1:0]  sample_word,
  input wire logic                          over_range_flag,
  input wire logic                          dataOe_n,
  input wire logic                          sampleValid,
  input wire logic                          stabOn,
  input wire logic                          twosComp,
  input wire logic                          refPowered,
  input wire logic                          corePowered
);
  import aoc_pkg::*;

  // ------------------------------------------------------------
  // Port relations, all on the sample clock
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Pin inputs pass two sync flops and a register, so five cycles suffice
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst |-> dataOe_n && !sampleValid)
    else $error("outputs active in reset");
  oe_hiz_a: assert property (outEnable_n[*5] |-> dataOe_n)
    else $error("bus driven while output enable high");
  valid_driven_a: assert property (sampleValid |-> !dataOe_n)
    else $error("new word while bus released");
  pd_hiz_a: assert property (power_down_pin[*5] |-> dataOe_n && !sampleValid)
    else $error("bus active in power down");
  sleep_off_a: assert property ((power_down_pin && outEnable_n)[*5] |->
    !refPowered && !corePowered)
    else $error("sleep left power on");
  nap_ref_a: assert property ((power_down_pin && !outEnable_n)[*5] |->
    refPowered && !corePowered)
    else $error("nap power domains wrong");
  cfg_fmt_a: assert property ($stable(cfgLevel)[*4] |-> twosComp == cfgLevel[1])
    else $error("coding decode wrong");
  cfg_stab_a: assert property ($stable(cfgLevel)[*4] |->
    stabOn == (cfgLevel[1] ^ cfgLevel[0]))
    else $error("stabilizer decode wrong");
  sat_code_a: assert property (sampleValid && over_range_flag |->
    sample_word[12:0] == {13{sample_word[SIGN_BIT] ^ twosComp}})
    else $error("flagged word not at an extreme code");
endmodule

bind aoc_top aoc_checker chk_u (.clk(clk), .sys_rst(sys_rst), .cfgLevel(cfgLevel),
  .outEnable_n(outEnable_n), .power_down_pin(power_down_pin), .sample_word(sample_word),
  .over_range_flag(over_range_flag), .dataOe_n(dataOe_n), .sampleValid(sampleValid),
  .stabOn(stabOn), .twosComp(twosComp), .refPowered(refPowered), .corePowered(corePowered));

// [sim/aoc_capture_model.sv]
`timescale 1ns/10ps
module aoc_capture_model (
  input wire logic                          clk,
  input wire logic [aoc_pkg::SAMPLE_W-1:0]  busWord,
  input wire logic                          busFlag,
  input wire logic                          busOe_n,
  input wire logic                          busValid,
  output logic     [aoc_pkg::SAMPLE_W:0]    capData,
  output logic                              capStrobe
);
  import aoc_pkg::*;

  // ------------------------------------------------------------
  // Capture register
  // ------------------------------------------------------------
  // Word and flag on one edge; a released bus is never taken
  always_ff @(posedge clk)
  begin
    capStrobe <= busValid && !busOe_n;
    if (busValid && !busOe_n)
    begin
      capData <= {busFlag, busWord};
    end
  end
endmodule
